/* rtl/sac_clkdiv.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"

module sac_clkdiv import sac_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control
	input wire logic run,
	input wire logic speed,
	// Converter clock tick
	output logic tick
);

	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic tick_reg;
	logic tick_next;
	logic [1:0] last;

	// Divide pclk by 4 or by 2 while the converter runs
	always_comb begin
		last = speed ? `SAC_DIV2_LAST : `SAC_DIV4_LAST;
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (run) begin
			if (cnt_reg >= last) begin
				cnt_next = 2'h0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 2'h1;
			end
		end else begin
			cnt_next = 2'h0;
		end
	end

	// Divider state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 2'h0;
			tick_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	chk_div4_period: assert property (@(posedge pclk) disable iff (!presetn)
		tick && run && !speed && clk_en ##1 (run && !speed && clk_en)[*3] |=> tick)
		else $error("divide by 4 tick period wrong");
	chk_div2_period: assert property (@(posedge pclk) disable iff (!presetn)
		tick && run && speed && clk_en ##1 (run && speed && clk_en) |=> tick)
		else $error("divide by 2 tick period wrong");

endmodule : sac_clkdiv
`default_nettype wire

/* rtl/sac_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"

module sac_ctrl import sac_pkg::*; (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Low-power modes
	input wire logic wait_mode,
	input wire logic halt_mode,
	// Analog core
	output sac_core_req_t core_req,
	input wire sac_core_rsp_t core_rsp
);

	// Bus state
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	// Control state
	sac_csr_t csr_reg;
	sac_csr_t csr_next;
	logic [7:0] drh_reg;
	logic [7:0] drh_next;
	logic [7:0] drl_reg;
	logic [7:0] drl_next;
	sac_state_t state_reg;
	sac_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic load_prev_reg;
	logic load_prev_next;
	sac_core_req_t req_reg;
	sac_core_req_t req_next;

	// Decoded strobes
	logic acc;
	logic done;
	logic hit_csr;
	logic hit_drh;
	logic hit_drl;
	logic wr_csr;
	logic rd_drh;
	logic run;
	logic tick;
	logic restart;
	logic load;

	// Address decode and transfer phases
	always_comb begin
		acc = psel && penable && !pready_reg;
		done = psel && penable && pready_reg;
		hit_csr = (paddr == `SAC_ADDR_CSR);
		hit_drh = (paddr == `SAC_ADDR_DRH);
		hit_drl = (paddr == `SAC_ADDR_DRL);
		wr_csr = done && pwrite && hit_csr && pstrb[0];
		rd_drh = done && !pwrite && hit_drh;
	end

	// One wait state, then answer; unmapped addresses give an error
	always_comb begin
		pready_next = acc;
		pslverr_next = acc && !(hit_csr || hit_drh || hit_drl);
		prdata_next = 32'h0;
		if (acc && !pwrite) begin
			if (hit_csr) begin
				prdata_next = {24'h0, csr_reg};
			end else if (hit_drh) begin
				prdata_next = {24'h0, drh_reg};
			end else if (hit_drl) begin
				prdata_next = {24'h0, drl_reg};
			end
		end
	end

	// Bus registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (clk_en) begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// Halt stops the converter, wait mode is ignored on purpose
	assign run = csr_reg.on && !halt_mode;

	// Converter clock divider
	sac_clkdiv i_sac_clkdiv (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.run(run),
		.speed(csr_reg.speed),
		.tick(tick)
	);

	// Status register, result registers and sequencer
	always_comb begin
		csr_next = csr_reg;
		drh_next = drh_reg;
		drl_next = drl_reg;
		state_next = state_reg;
		cnt_next = cnt_reg;
		req_next = req_reg;
		restart = wr_csr && (pwdata[3:0] != csr_reg.chan) && run;
		load = (state_reg == SAC_CONVERT) && core_rsp.done && run && !restart;
		load_prev_next = load;
		// Software write with pstrb[0]; reserved bit is not writable and the write clears the flag unless a completion loads in the same cycle
		if (wr_csr) begin
			csr_next = sac_csr_t'((pwdata[7:0] & `SAC_CSR_WMASK) | {csr_reg.eoc, 7'h0});
			csr_next.rsvd = 1'b0;
			csr_next.eoc = 1'b0;
		end
		// A high byte read clears the flag unless a new result just landed
		if (rd_drh && !load_prev_reg) begin
			csr_next.eoc = 1'b0;
		end
		// Sequencer
		unique case (state_reg)
			SAC_OFF: begin
				cnt_next = 4'h0;
				if (run) begin
					state_next = SAC_SAMPLE;
				end
			end
			SAC_SAMPLE: begin
				if (tick && clk_en) begin
					if (cnt_reg == `SAC_SAMPLE_TICKS - 4'h1) begin
						cnt_next = 4'h0;
						state_next = SAC_CONVERT;
					end else begin
						cnt_next = cnt_reg + 4'h1;
					end
				end
			end
			SAC_CONVERT: begin
				if (load) begin
					state_next = SAC_SAMPLE;
					cnt_next = 4'h0;
				end
			end
		endcase
		// Every completion overwrites both result registers
		if (load) begin
			drh_next = core_rsp.result[9:2];
			drl_next = {6'h0, core_rsp.result[1:0]};
			csr_next.eoc = 1'b1;
		end
		// New channel: abort and start sampling it at once
		if (restart) begin
			state_next = SAC_SAMPLE;
			cnt_next = 4'h0;
		end
		// Converter off or halted: stop whatever is in progress
		if (!run) begin
			state_next = SAC_OFF;
			cnt_next = 4'h0;
		end
		// Power, sample and start requests follow the next state; tick follows the divider and chan the next selection
		req_next.power = (state_next != SAC_OFF);
		req_next.sample = (state_next == SAC_SAMPLE);
		req_next.start = (state_next == SAC_CONVERT) && (state_reg != SAC_CONVERT);
		req_next.tick = tick && run;
		req_next.chan = csr_next.chan;
	end

	// Control registers; all clear on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr_reg <= sac_csr_t'(`SAC_CSR_RST);
			drh_reg <= `SAC_DRH_RST;
			drl_reg <= `SAC_DRL_RST;
			state_reg <= SAC_OFF;
			cnt_reg <= 4'h0;
			load_prev_reg <= 1'b0;
			req_reg <= '0;
		end else if (clk_en) begin
			csr_reg <= csr_next;
			drh_reg <= drh_next;
			drl_reg <= drl_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			load_prev_reg <= load_prev_next;
			req_reg <= req_next;
		end
	end

	// Outputs straight from flip-flops; no interrupt output exists
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign core_req = req_reg;

	// Checks
	chk_eoc_on_load: assert property (@(posedge pclk) disable iff (!presetn)
		load && clk_en |=> csr_reg.eoc)
		else $error("flag not set after completion");
	chk_high_result: assert property (@(posedge pclk) disable iff (!presetn)
		load && clk_en |=> drh_reg == $past(core_rsp.result[9:2]))
		else $error("high result bits wrong");
	chk_low_result: assert property (@(posedge pclk) disable iff (!presetn)
		load && clk_en |=> drl_reg == {6'h0, $past(core_rsp.result[1:0])})
		else $error("low result bits wrong");
	chk_off_stops: assert property (@(posedge pclk) disable iff (!presetn)
		!csr_reg.on && clk_en |=> state_reg == SAC_OFF && !core_req.power)
		else $error("converter still active when off");
	chk_halt_stops: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode && clk_en |=> !core_req.power)
		else $error("converter powered in halt");
	chk_chan_restart: assert property (@(posedge pclk) disable iff (!presetn)
		restart && clk_en |=> state_reg == SAC_SAMPLE && !csr_reg.eoc && cnt_reg == 4'h0)
		else $error("channel change did not restart");
	chk_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
		wr_csr && !load && clk_en |=> !csr_reg.eoc)
		else $error("status write kept flag");
	chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		csr_reg.rsvd == 1'b0 && drl_reg[7:2] == 6'h0)
		else $error("reserved bits not zero");
	chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready && clk_en |=> pready ##1 !pready)
		else $error("bus answer timing wrong");
	chk_continuous: assert property (@(posedge pclk) disable iff (!presetn)
		load && clk_en && !wr_csr && !halt_mode |=> state_reg == SAC_SAMPLE && core_req.sample)
		else $error("conversion did not continue");

	// Status register and result register checks
	chk_rd_clears: assert property (@(posedge pclk) disable iff (!presetn)
		rd_drh && !load_prev_reg && !load && clk_en |=> !csr_reg.eoc)
		else $error("high result read kept flag");
	chk_eoc_source: assert property (@(posedge pclk) disable iff (!presetn)
		!csr_reg.eoc && !load && clk_en |=> !csr_reg.eoc)
		else $error("flag set without completion");
	chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!load && clk_en |=> drh_reg == $past(drh_reg) && drl_reg == $past(drl_reg))
		else $error("result changed without completion");
	chk_csr_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_csr && clk_en |=> csr_reg[6:0] == ($past(pwdata[6:0]) & 7'h6f))
		else $error("status write not taken");
	chk_halt_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode && !wr_csr && clk_en |=> csr_reg.on == $past(csr_reg.on))
		else $error("halt changed the on bit");

	// Bus read data and error response checks
	chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pwrite && hit_drh && clk_en |=> prdata == {24'h0, $past(drh_reg)})
		else $error("high result read data wrong");
	chk_low_read: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pwrite && hit_drl && clk_en |=> prdata[31:2] == 30'h0)
		else $error("low result upper bits not zero");
	chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !(hit_csr || hit_drh || hit_drl) && clk_en |=> pslverr)
		else $error("unmapped address without error");

	// Sequencer and core request checks
	chk_power_on: assert property (@(posedge pclk) disable iff (!presetn)
		run && clk_en |=> core_req.power)
		else $error("converter not powered while on");
	chk_tick_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!run && clk_en |=> !core_req.tick)
		else $error("converter ticks while stopped");
	chk_start_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		core_req.start && clk_en |=> !core_req.start)
		else $error("start request longer than one cycle");
	chk_sample_len: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SAC_SAMPLE && state_next == SAC_CONVERT |-> tick && cnt_reg == `SAC_SAMPLE_TICKS - 4'h1)
		else $error("sampling window length wrong");
	chk_chan_route: assert property (@(posedge pclk) disable iff (!presetn)
		core_req.chan == csr_reg.chan)
		else $error("core channel differs from selection");

	// Main scenarios
	cov_load: cover property (@(posedge pclk) disable iff (!presetn) load && clk_en);
	cov_restart: cover property (@(posedge pclk) disable iff (!presetn) restart && clk_en);
	cov_drh_clear: cover property (@(posedge pclk) disable iff (!presetn) rd_drh && csr_reg.eoc && clk_en);
	cov_halt: cover property (@(posedge pclk) disable iff (!presetn) halt_mode && csr_reg.on && clk_en);
	cov_fast_div: cover property (@(posedge pclk) disable iff (!presetn) tick && csr_reg.speed && clk_en);

	// Wait mode needs no handling; it is read here only to document the port
	logic unused_ok;
	assign unused_ok = wait_mode && (|pwdata[31:8]) && (|pstrb[3:1]);

endmodule : sac_ctrl
`default_nettype wire

/* rtl/sac_params.svh */
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Register indices and their word byte addresses
`define SAC_IDX_CSR 10'h070
`define SAC_IDX_DRH 10'h071
`define SAC_IDX_DRL 10'h072
`define SAC_ADDR_CSR {`SAC_IDX_CSR, 2'h0}
`define SAC_ADDR_DRH {`SAC_IDX_DRH, 2'h0}
`define SAC_ADDR_DRL {`SAC_IDX_DRL, 2'h0}

// Field positions
`define SAC_EOC_BIT 7
`define SAC_SPEED_BIT 6
`define SAC_ON_BIT 5
`define SAC_RSVD_BIT 4

// Reset values and write mask
`define SAC_CSR_RST 8'h00
`define SAC_DRH_RST 8'h00
`define SAC_DRL_RST 8'h00
`define SAC_CSR_WMASK 8'h6f

// Timing counts in converter clock ticks and in pclk cycles
`define SAC_SAMPLE_TICKS 4'h4
`define SAC_DIV4_LAST 2'h3
`define SAC_DIV2_LAST 2'h1

`endif

/* rtl/sac_pkg.sv */
package sac_pkg;

	// Control/status register layout
	typedef struct packed {
		logic eoc;
		logic speed;
		logic on;
		logic rsvd;
		logic [3:0] chan;
	} sac_csr_t;

	// Request to the analog sampling core
	typedef struct packed {
		logic power;
		logic sample;
		logic start;
		logic tick;
		logic [3:0] chan;
	} sac_core_req_t;

	// Answer of the analog sampling core
	typedef struct packed {
		logic done;
		logic [9:0] result;
	} sac_core_rsp_t;

	// Conversion sequencer
	typedef enum logic [1:0] {
		SAC_OFF,
		SAC_SAMPLE,
		SAC_CONVERT
	} sac_state_t;

endpackage : sac_pkg

/* verification/sac_core_model.sv */
`timescale 1ns/100ps
`default_nettype none

module sac_core_model import sac_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controller side
	input wire sac_core_req_t req,
	output sac_core_rsp_t rsp,
	// Analog level and conversion length in pclk cycles
	input wire logic [5:0] level,
	input wire logic [7:0] lat
);
	logic busy;
	logic [7:0] cnt;
	logic [9:0] last;

	// Result carries data only with done, else the inverted last value
	always_comb begin
		rsp.done = busy && (cnt == lat);
		rsp.result = rsp.done ? {req.chan, level} : ~last;
	end

	// Start arms the timer, power loss aborts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			last <= 10'h000;
		end else if (!req.power || req.start) begin
			busy <= req.start && req.power;
			cnt <= 8'h00;
		end else if (busy) begin
			cnt <= cnt + 8'h01;
			busy <= !rsp.done;
			last <= rsp.done ? rsp.result : last;
		end
	end
endmodule : sac_core_model

`default_nettype wire

/* verification/tb_sac_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_params.svh"

module tb_sac_ctrl;
	import sac_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] pstrb = 4'hf;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic wait_mode = 1'b0;
	logic halt_mode = 1'b0;
	logic [5:0] level = 6'h00;
	logic [7:0] lat = 8'h1e;
	sac_core_req_t core_req;
	sac_core_rsp_t core_rsp;
	int failures = 0;
	int num_checks = 0;
	logic [31:0] r;
	logic e;

	// Clock
	always #5 pclk = ~pclk;

	sac_ctrl i_sac_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .halt_mode(halt_mode),
		.core_req(core_req), .core_rsp(core_rsp));
	sac_core_model i_sac_core_model (.pclk(pclk), .presetn(presetn), .req(core_req), .rsp(core_rsp),
		.level(level), .lat(lat));

	// One APB transfer; result in r and e
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Poll the status register until the end flag shows
	task automatic wait_eoc;
		int n;
		n = 0;
		do begin
			apb(1'b0, `SAC_ADDR_CSR, 8'h00);
			n++;
		end while (r[7] !== 1'b1 && n < 60);
		chk({31'h0, r[7]}, 32'h1);
	endtask : wait_eoc

	// Start a channel, measure the tick spacing, read the result
	task automatic t_conv(input logic [3:0] ch, input logic sp);
		logic [9:0] res;
		int n;
		res = {ch, ch[1:0], ch};
		level <= {ch[1:0], ch};
		apb(1'b1, `SAC_ADDR_CSR, {1'b0, sp, 1'b1, 1'b0, ch});
		n = 0;
		while (core_req.tick !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		n = 1;
		while (core_req.tick !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n), sp ? 32'h2 : 32'h4);
		wait_eoc();
		apb(1'b0, `SAC_ADDR_DRL, 8'h00);
		chk(r, {30'h0, res[1:0]});
		apb(1'b0, `SAC_ADDR_DRH, 8'h00);
		chk(r, {24'h0, res[9:2]});
		apb(1'b0, `SAC_ADDR_CSR, 8'h00);
		chk(r, {25'h0, sp, 1'b1, 1'b0, ch});
	endtask : t_conv

	// Read-only places, reserved bit and an unmapped address
	task automatic t_access;
		apb(1'b1, `SAC_ADDR_CSR, 8'hdf);
		apb(1'b0, `SAC_ADDR_CSR, 8'h00);
		chk(r, 32'h4f);
		apb(1'b1, `SAC_ADDR_DRH, 8'h55);
		apb(1'b0, `SAC_ADDR_DRH, 8'h00);
		chk(r, 32'h0);
		apb(1'b0, 12'h1cc, 8'h00);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
	endtask : t_access

	// Channel change with flag set, then an unread result overwritten
	task automatic t_abort;
		int n;
		wait_eoc();
		apb(1'b1, `SAC_ADDR_CSR, 8'h23);
		apb(1'b0, `SAC_ADDR_CSR, 8'h00);
		chk(r, 32'h23);
		wait_eoc();
		level <= 6'h2a;
		n = 0;
		while (core_rsp.done !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		apb(1'b0, `SAC_ADDR_DRH, 8'h00);
		chk(r, 32'h3a);
		apb(1'b0, `SAC_ADDR_CSR, 8'h00);
		chk(r, 32'h23);
	endtask : t_abort

	// A low clock enable freezes every request to the core
	task automatic t_freeze;
		sac_core_req_t held;
		clk_en <= 1'b0;
		@(posedge pclk);
		held = core_req;
		repeat (10) begin
			@(posedge pclk);
			chk({24'h0, core_req}, {24'h0, held});
		end
		clk_en <= 1'b1;
		@(posedge pclk);
	endtask : t_freeze

	// Halt stops the converter, clearing the on bit disables it
	task automatic t_off;
		halt_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({31'h0, core_req.power}, 32'h0);
		halt_mode <= 1'b0;
		repeat (20) @(posedge pclk);
		chk({31'h0, core_req.power}, 32'h1);
		apb(1'b1, `SAC_ADDR_CSR, 8'h03);
		repeat (150) @(posedge pclk);
		apb(1'b0, `SAC_ADDR_CSR, 8'h00);
		chk(r, 32'h3);
		chk({31'h0, core_req.power}, 32'h0);
	endtask : t_off

	task automatic give_verdict;
		$display("Checks made %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, `SAC_ADDR_CSR + 12'(i * 4), 8'h00);
			chk(r, 32'h0);
		end
		t_access();
		for (int i = 0; i < 16; i++) begin
			wait_mode <= (i == 5);
			lat <= i[0] ? 8'h1e : 8'h5a;
			t_conv(4'(i), i[0]);
		end
		t_abort();
		t_freeze();
		t_off();
		give_verdict();
	end

	// Watchdog
	initial begin
		#300us;
		failures++;
		give_verdict();
	end
endmodule : tb_sac_ctrl

`default_nettype wire
